// [dpdr_pkg.sv]
// Purpose: Shared constants for the periodic data responder
// Assumes: Field widths and codes fixed by the periodic frame format
// Notes:   Register offsets are local choices on a plain register port
package dpdr_pkg;
	// Register offsets (8-bit address)
	localparam logic [7:0] ADDR_DIAG_CFG   = 8'h00;
	localparam logic [7:0] ADDR_SRC_CFG0   = 8'h04;
	localparam logic [7:0] ADDR_STATUS     = 8'h10;
	localparam logic [7:0] ADDR_DIAG_CMD   = 8'h14;
	localparam logic [7:0] ADDR_LOCK       = 8'h18;
	// Diag config fields
	localparam int DIAG_EN_BIT   = 0;
	localparam int FRAG_SIZE_BIT = 1;
	localparam int SUP_OFF_BIT   = 2;
	// Source config fields
	localparam int SRC_ID_LSB    = 0;
	localparam int SRC_FMT_LSB   = 4;
	localparam int SRC_DSEL_LSB  = 8;
	// Command framing
	localparam logic [5:0] CMD_BITS    = 6'h20;
	localparam logic [3:0] CMD_ENTER   = 4'hB;
	localparam logic [3:0] ADDR_GLOBAL = 4'h0;
	// Status codes
	localparam logic [3:0] STS_NORMAL   = 4'h0;
	localparam logic [3:0] STS_UNLOCKED = 4'h1;
	localparam logic [3:0] STS_SELFTEST = 4'h2;
	localparam logic [3:0] STS_OSC      = 4'h3;
	localparam logic [3:0] STS_PABS     = 4'h4;
	localparam logic [3:0] STS_TEMP     = 4'h5;
	localparam logic [3:0] STS_UOTP     = 4'h8;
	localparam logic [3:0] STS_URW      = 4'h9;
	localparam logic [3:0] STS_FOTP     = 4'hA;
	localparam logic [3:0] STS_TEST     = 4'hB;
	localparam logic [3:0] STS_SUPPLY   = 4'hC;
	localparam logic [15:0] DATA_ERR_CODE = 16'h8000;
	localparam logic [7:0]  CRC_POLY      = 8'h2F;
	localparam logic [7:0]  CRC_SEED      = 8'hFF;
	// Frame format encodings (field widths per format)
	localparam logic [2:0] FMT_FULL   = 3'h0; // id4 kac2 sts4 data16
	localparam logic [2:0] FMT_NOSTS  = 3'h1; // id4 kac2 data16
	localparam logic [2:0] FMT_DATA   = 3'h2; // data16 only
endpackage

// [dpdr_top.sv]
// Purpose: Slave logic for periodic data collection with background diag
// Assumes: Decoded commands arrive from the physical layer as bit counts
// Notes:   Response fields are assembled here, serialised elsewhere
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module dpdr_top #(
	parameter int NUM_SRC   = 4,
	parameter int DATA_W    = 16
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	// Received command from physical decoder
	input  wire logic                cmd_valid,
	input  wire logic [5:0]          cmd_len,
	input  wire logic [3:0]          cmd_bits,
	input  wire logic                cmd_crc_ok,
	input  wire logic [3:0]          phys_addr,
	// Source slot selection and measurements
	input  wire logic [1:0]          slot_src,
	input  wire logic [4*DATA_W-1:0] meas_bus,
	// Condition flags (already on clk domain)
	input  wire logic                user_unlocked,
	input  wire logic                selftest_incomplete,
	input  wire logic                selftest_running,
	input  wire logic                selftest_fault,
	input  wire logic                osc_error,
	input  wire logic                abs_pressure_over,
	input  wire logic                abs_pressure_under,
	input  wire logic                abs_pressure_disagree,
	input  wire logic                temp_error,
	input  wire logic                user_otp_error,
	input  wire logic                user_rw_error,
	input  wire logic                factory_otp_error,
	input  wire logic                test_active_flag,
	input  wire logic                supply_error,
	input  wire logic                supply_timer_done,
	// Response out
	output logic                     resp_valid,
	output logic [3:0]               resp_src_id,
	output logic [1:0]               resp_keep_alive,
	output logic [3:0]               resp_status,
	output logic [DATA_W-1:0]        resp_data,
	output logic [7:0]               resp_crc,
	output logic [2:0]               resp_format,
	output logic                     diag_cmd_valid,
	output logic [31:0]              diag_cmd,
	output logic                     periodic_collection_mode
);

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic                      lock;
		logic [2:0]                diag_cfg;
		logic [NUM_SRC-1:0][11:0]  src_cfg;
		logic [NUM_SRC-1:0][1:0]   keep_alive_count;
		logic [31:0]               asm_cmd;
		logic [5:0]                asm_cnt;
		logic [31:0]               rdata;
		logic                      rvalid;
		logic [3:0]                rsrc;
		logic [1:0]                rkac;
		logic [3:0]                rsts;
		logic [DATA_W-1:0]         rdat;
		logic [7:0]                rcrc;
		logic [2:0]                rfmt;
		logic                      dvalid;
		logic [31:0]               dcmd;
	} dpdr_state_s;

	dpdr_state_s state_r;
	dpdr_state_s state_nxt;

	////////////////////////////////////////////////////////////////////
	// CRC over a 26-bit frame image, MSB first
	function automatic logic [7:0] dpdr_crc(input logic [25:0] msg);
		logic [7:0] c;
		c = dpdr_pkg::CRC_SEED;
		for (int i = 25; i >= 0; i--) begin
			if (c[7] ^ msg[i]) begin
				c = {c[6:0], 1'b0} ^ dpdr_pkg::CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////
	logic [3:0]        sts_code;
	logic              hard_err;
	logic              soft_err;
	logic              diag_en;
	logic              frag4;
	logic [5:0]        frag_len;
	logic [11:0]       cur_cfg;
	logic [2:0]        cur_fmt;
	logic [DATA_W-1:0] cur_meas;
	logic [31:0]       asm_next;
	logic [25:0]       crc_img;
	logic              respond;
	logic              is_bcast;
	logic              is_frag;

	// Priority chain: earlier branch has the smaller priority number
	always_comb begin
		sts_code = dpdr_pkg::STS_NORMAL;
		hard_err = 1'b0;
		if (supply_error && !state_r.diag_cfg[dpdr_pkg::SUP_OFF_BIT]) begin
			sts_code = dpdr_pkg::STS_SUPPLY;
			hard_err = 1'b1;
		end else if (test_active_flag) begin
			sts_code = dpdr_pkg::STS_TEST;
			hard_err = 1'b1;
		end else if (factory_otp_error) begin
			sts_code = dpdr_pkg::STS_FOTP;
			hard_err = 1'b1;
		end else if (user_rw_error) begin
			sts_code = dpdr_pkg::STS_URW;
			hard_err = 1'b1;
		end else if (user_otp_error) begin
			sts_code = dpdr_pkg::STS_UOTP;
			hard_err = 1'b1;
		end else if (temp_error) begin
			sts_code = dpdr_pkg::STS_TEMP;
		end else if (abs_pressure_over || abs_pressure_under
				|| abs_pressure_disagree) begin
			sts_code = dpdr_pkg::STS_PABS;
		end else if (osc_error) begin
			sts_code = dpdr_pkg::STS_OSC;
		end else if (selftest_incomplete || selftest_running
				|| selftest_fault) begin
			sts_code = dpdr_pkg::STS_SELFTEST;
		end else if (user_unlocked) begin
			sts_code = dpdr_pkg::STS_UNLOCKED;
		end
		soft_err = (sts_code != dpdr_pkg::STS_NORMAL) && !hard_err;
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		state_nxt.rvalid = 1'b0;
		state_nxt.dvalid = 1'b0;
		diag_en  = state_r.lock && state_r.diag_cfg[dpdr_pkg::DIAG_EN_BIT];
		frag4    = state_r.diag_cfg[dpdr_pkg::FRAG_SIZE_BIT];
		frag_len = frag4 ? 6'h04 : 6'h02;
		cur_cfg  = state_r.src_cfg[slot_src];
		cur_fmt  = cur_cfg[dpdr_pkg::SRC_FMT_LSB +: 3];
		cur_meas = meas_bus[cur_cfg[dpdr_pkg::SRC_DSEL_LSB +: 2]*DATA_W
			+: DATA_W];
		// Any value of the single bit is a broadcast read, unchecked
		is_bcast = cmd_valid && (cmd_len == 6'h01);
		is_frag  = cmd_valid && diag_en && (cmd_len == frag_len);
		respond  = state_r.lock && (diag_en ? (is_bcast || is_frag)
			: is_bcast);
		asm_next = state_r.asm_cmd;
		if (frag4) begin
			asm_next = {state_r.asm_cmd[27:0], cmd_bits};
		end else begin
			asm_next = {state_r.asm_cmd[29:0], cmd_bits[1:0]};
		end
		crc_img = 26'h0;

		// Enter-periodic command in command mode; lock clears only on reset
		if (cmd_valid && !state_r.lock && cmd_len == dpdr_pkg::CMD_BITS
				&& cmd_crc_ok && cmd_bits == dpdr_pkg::CMD_ENTER
				&& (phys_addr == dpdr_pkg::ADDR_GLOBAL
				|| phys_addr == state_r.asm_cmd[3:0])) begin
			state_nxt.lock = 1'b1;
		end

		// Fragment reassembly
		if (cmd_valid && diag_en) begin
			if (is_frag) begin
				state_nxt.asm_cmd = asm_next;
				if (state_r.asm_cnt + frag_len >= dpdr_pkg::CMD_BITS) begin
					state_nxt.asm_cnt = 6'h00;
					// Only the completing fragment's cmd_crc_ok is checked
					if (cmd_crc_ok) begin
						state_nxt.dvalid = 1'b1;
						state_nxt.dcmd   = asm_next;
					end
				end else begin
					state_nxt.asm_cnt = state_r.asm_cnt + frag_len;
				end
			end else begin
				state_nxt.asm_cnt = 6'h00;
				state_nxt.asm_cmd = 32'h0;
			end
		end

		// Supply error holds off response until the monitor timer ends
		if (respond && !(sts_code == dpdr_pkg::STS_SUPPLY
				&& !supply_timer_done)) begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rfmt   = cur_fmt;
			state_nxt.rsrc   = cur_cfg[dpdr_pkg::SRC_ID_LSB +: 4];
			state_nxt.rkac   = state_r.keep_alive_count[slot_src];
			state_nxt.keep_alive_count[slot_src] = state_r.keep_alive_count[slot_src] + 2'h1;
			state_nxt.rsts   = (cur_fmt == dpdr_pkg::FMT_FULL)
				? sts_code : 4'h0;
			if (hard_err || (soft_err && cur_fmt != dpdr_pkg::FMT_FULL)) begin
				state_nxt.rdat = dpdr_pkg::DATA_ERR_CODE[DATA_W-1:0];
			end else begin
				state_nxt.rdat = cur_meas;
			end
			crc_img = {state_nxt.rsrc, state_nxt.rkac, state_nxt.rsts,
				state_nxt.rdat[15:0]};
			state_nxt.rcrc = dpdr_crc(crc_img);
		end

		// Register port
		state_nxt.rdata = 32'h0;
		if (reg_wr) begin
			case (reg_addr)
				dpdr_pkg::ADDR_DIAG_CFG: begin
					state_nxt.diag_cfg = reg_wdata[2:0];
				end
				default: begin
					for (int i = 0; i < NUM_SRC; i++) begin
						if (reg_addr == dpdr_pkg::ADDR_SRC_CFG0
								+ 8'(4*i) && !state_r.lock) begin
							state_nxt.src_cfg[i] = reg_wdata[11:0];
						end
					end
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				dpdr_pkg::ADDR_DIAG_CFG: begin
					state_nxt.rdata = {29'h0, state_r.diag_cfg};
				end
				dpdr_pkg::ADDR_STATUS: begin
					state_nxt.rdata = {26'h0, state_r.asm_cnt};
					state_nxt.rdata[11:8] = sts_code;
				end
				dpdr_pkg::ADDR_DIAG_CMD: begin
					state_nxt.rdata = state_r.dcmd;
				end
				dpdr_pkg::ADDR_LOCK: begin
					state_nxt.rdata = {31'h0, state_r.lock};
				end
				default: begin
					for (int i = 0; i < NUM_SRC; i++) begin
						if (reg_addr == dpdr_pkg::ADDR_SRC_CFG0 + 8'(4*i)) begin
							state_nxt.rdata = {20'h0, state_r.src_cfg[i]};
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata                = state_r.rdata;
	assign resp_valid               = state_r.rvalid;
	assign resp_src_id              = state_r.rsrc;
	assign resp_keep_alive          = state_r.rkac;
	assign resp_status              = state_r.rsts;
	assign resp_data                = state_r.rdat;
	assign resp_crc                 = state_r.rcrc;
	assign resp_format              = state_r.rfmt;
	assign diag_cmd_valid           = state_r.dvalid;
	assign diag_cmd                 = state_r.dcmd;
	assign periodic_collection_mode = state_r.lock;

endmodule // dpdr_top

// [dpdr_mst.sv]
// Purpose: Bus master model issuing decoded commands to the responder
// Assumes: Commands arrive already counted in bits
// Notes:   Released bits flip so a stale value is never mistaken for data
`timescale 1ns/1ps
module dpdr_mst (
	// Clock
	input  wire logic  clk,
	// Command out
	output logic       cmd_valid,
	output logic [5:0] cmd_len,
	output logic [3:0] cmd_bits,
	output logic       cmd_crc_ok,
	output logic [3:0] phys_addr
);
	initial begin
		cmd_valid = 1'h0;
		cmd_len = 6'h00;
		cmd_bits = 4'h0;
		cmd_crc_ok = 1'h0;
		phys_addr = 4'h0;
	end
	// One command per call; a broadcast may carry either value
	task automatic send(input logic [5:0] len, input logic [3:0] bits);
		@(posedge clk);
		cmd_valid <= 1'h1;
		cmd_len <= len;
		cmd_bits <= bits;
		cmd_crc_ok <= 1'h1;
		phys_addr <= 4'h0;
		@(posedge clk);
		cmd_valid <= 1'h0;
		cmd_bits <= ~bits;
		cmd_crc_ok <= 1'h0;
		phys_addr <= 4'hF;
	endtask
endmodule // dpdr_mst

// [dpdr_chk_assertions.sv]
// Purpose: Port-level checks for the periodic data responder
// Assumes: Supply error reporting left enabled
// Notes:   Keep-alive tracked per source in helper logic
`timescale 1ns/1ps
module dpdr_chk #(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              reset_n,
	// Observed ports
	input wire logic              cmd_valid,
	input wire logic [5:0]        cmd_len,
	input wire logic [1:0]        slot_src,
	input wire logic              supply_error,
	input wire logic              supply_timer_done,
	input wire logic              resp_valid,
	input wire logic [1:0]        resp_keep_alive,
	input wire logic [3:0]        resp_status,
	input wire logic [DATA_W-1:0] resp_data,
	input wire logic [2:0]        resp_format,
	input wire logic              periodic_collection_mode
);
	logic [1:0] kac_r [4];
	logic [1:0] src_r;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			kac_r <= '{default: 2'h0};
			src_r <= 2'h0;
		end else begin
			if (cmd_valid)
				src_r <= slot_src;
			if (resp_valid)
				kac_r[src_r] <= kac_r[src_r] + 2'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	no_early_resp_a:
		assert property (cmd_valid && !periodic_collection_mode |=> !resp_valid)
		else $error("response before lock");
	lock_hold_a:
		assert property (periodic_collection_mode |=> periodic_collection_mode)
		else $error("lock bit dropped");
	resp_cause_a:
		assert property (!cmd_valid |=> !resp_valid)
		else $error("response without command");
	bcast_answer_a:
		assert property (cmd_valid && cmd_len == 6'h01 && periodic_collection_mode
			&& (!supply_error || supply_timer_done) |=> resp_valid)
		else $error("broadcast read not answered");
	bad_len_a:
		assert property (cmd_valid && !(cmd_len inside {6'h01, 6'h02, 6'h04})
			|=> !resp_valid) else $error("odd length answered");
	supply_quiet_a:
		assert property (cmd_valid && supply_error && !supply_timer_done
			|=> !resp_valid) else $error("answer during supply error");
	err_data_a:
		assert property (resp_valid && resp_status inside {[4'h8:4'hC]}
			|-> resp_data == dpdr_pkg::DATA_ERR_CODE) else $error("no error code");
	nosts_zero_a:
		assert property (resp_valid && resp_format != dpdr_pkg::FMT_FULL
			|-> resp_status == 4'h0) else $error("status sent without field");
	kac_step_a:
		assert property (resp_valid |-> resp_keep_alive == kac_r[src_r])
		else $error("keep-alive count wrong");
endmodule // dpdr_chk
bind dpdr_top dpdr_chk #(.DATA_W(DATA_W)) u_chk (
	.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_len(cmd_len),
	.slot_src(slot_src), .supply_error(supply_error),
	.supply_timer_done(supply_timer_done), .resp_valid(resp_valid),
	.resp_keep_alive(resp_keep_alive), .resp_status(resp_status),
	.resp_data(resp_data), .resp_format(resp_format),
	.periodic_collection_mode(periodic_collection_mode)
);

// [testbench.sv]
// Purpose: Self-checking bench for the periodic data responder
// Assumes: Sources 0 and 1 are set up before the lock bit is set
// Notes:   Source config is frozen by the lock, so it is written first
`timescale 1ns/1ps
module testbench;
	logic        clk, reset_n, reg_wr, reg_rd, tmr;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        cmd_valid, cmd_crc_ok, resp_valid, mode;
	logic [5:0]  cmd_len;
	logic [3:0]  cmd_bits, phys_addr, resp_src_id, resp_status;
	logic [1:0]  slot_src, resp_keep_alive;
	logic [13:0] flg;
	logic [15:0] resp_data;
	logic [7:0]  crc;
	logic [2:0]  fmt;
	logic [31:0] diag_c;
	logic        diag_v;
	int          mismatches = 0;
	int          samples_checked = 0;
	dpdr_mst u_mst (.clk(clk), .cmd_valid(cmd_valid), .cmd_len(cmd_len),
		.cmd_bits(cmd_bits), .cmd_crc_ok(cmd_crc_ok), .phys_addr(phys_addr));
	dpdr_top u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_len(cmd_len),
		.cmd_bits(cmd_bits), .cmd_crc_ok(cmd_crc_ok), .phys_addr(phys_addr),
		.slot_src(slot_src), .meas_bus(64'h4444_3333_2222_1111),
		.user_unlocked(flg[0]), .selftest_incomplete(flg[1]),
		.selftest_running(flg[2]), .selftest_fault(flg[3]),
		.osc_error(flg[4]), .abs_pressure_over(flg[5]),
		.abs_pressure_under(flg[6]), .abs_pressure_disagree(flg[7]),
		.temp_error(flg[8]), .user_otp_error(flg[9]),
		.user_rw_error(flg[10]), .factory_otp_error(flg[11]),
		.test_active_flag(flg[12]), .supply_error(flg[13]),
		.supply_timer_done(tmr), .resp_valid(resp_valid),
		.resp_src_id(resp_src_id), .resp_keep_alive(resp_keep_alive),
		.resp_status(resp_status), .resp_data(resp_data), .resp_crc(crc),
		.resp_format(fmt), .diag_cmd_valid(diag_v), .diag_cmd(diag_c),
		.periodic_collection_mode(mode));
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Expected frame CRC, MSB first over id, keep-alive, status, data
	function automatic logic [7:0] crc8(input logic [25:0] m);
		logic [7:0] c;
		c = dpdr_pkg::CRC_SEED;
		for (int i = 25; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? dpdr_pkg::CRC_POLY : 8'h00);
		end
		return c;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	// Sends one command and judges whether a response followed
	task automatic cmd(input logic [5:0] n, input logic [3:0] b, input logic e);
		u_mst.send(n, b);
		#1 chk("resp_valid", {31'h0, e}, {31'h0, resp_valid});
	endtask
	task automatic t_pre;
		logic [31:0] d;
		cmd(6'h01, 4'h1, 1'h0);
		rd(8'hFC, d);
		chk("unmapped", 32'h0, d);
	endtask
	task automatic t_lock;
		wr(8'h04, 32'h0000_0205);
		wr(8'h08, 32'h0000_0119);
		cmd(6'h20, dpdr_pkg::CMD_ENTER, 1'h0);
		chk("mode", 32'h1, {31'h0, mode});
	endtask
	task automatic t_bcast;
		for (int i = 0; i < 5; i++) begin
			cmd(6'h01, i[3:0], 1'h1);
			chk("src_id", 32'h5, {28'h0, resp_src_id});
			chk("kac", i & 3, {30'h0, resp_keep_alive});
			chk("data", 32'h3333, {16'h0, resp_data});
			chk("format", 32'h0, {29'h0, fmt});
		end
	endtask
	task automatic t_len;
		cmd(6'h02, 4'h1, 1'h0);
		wr(dpdr_pkg::ADDR_DIAG_CFG, 32'h1);
		cmd(6'h02, 4'h2, 1'h1);
		cmd(6'h03, 4'h2, 1'h0);
	endtask
	task automatic t_nosts;
		@(posedge clk);
		slot_src <= 2'h1;
		flg <= 14'h0001;
		cmd(6'h01, 4'h0, 1'h1);
		chk("src_id", 32'h9, {28'h0, resp_src_id});
		chk("kac", 32'h0, {30'h0, resp_keep_alive});
		chk("status", 32'h0, {28'h0, resp_status});
		chk("data", 32'h8000, {16'h0, resp_data});
		chk("format", 32'h1, {29'h0, fmt});
		chk("crc", {24'h0, crc8({4'h9, 2'h0, 4'h0, 16'h8000})}, {24'h0, crc});
		@(posedge clk);
		slot_src <= 2'h0;
	endtask
	// Sixteen 2-bit fragments build one command, then one register read collects it
	task automatic t_diag;
		logic [31:0] d;
		for (int i = 0; i < 16; i++) begin
			cmd(6'h02, i[3:0] & 4'h3, 1'h1);
			chk("diag_valid", {31'h0, i == 15}, {31'h0, diag_v});
		end
		chk("diag_cmd", 32'h1B1B_1B1B, diag_c);
		rd(dpdr_pkg::ADDR_DIAG_CMD, d);
		chk("diag_reg", 32'h1B1B_1B1B, d);
		for (int i = 0; i < 8; i++) begin
			cmd(6'h01, 4'h1, 1'h1);
		end
	endtask
	task automatic t_status;
		logic [13:0] f [13] = '{14'h0001, 14'h0002, 14'h0004, 14'h0008,
			14'h0011, 14'h0020, 14'h0040, 14'h0080, 14'h0190, 14'h0300,
			14'h0600, 14'h0800, 14'h1E00};
		logic [3:0] c [13] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4,
			4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB};
		for (int i = 0; i < 13; i++) begin
			@(posedge clk);
			flg <= f[i];
			cmd(6'h01, 4'h1, 1'h1);
			chk("status", {28'h0, c[i]}, {28'h0, resp_status});
			chk("data", c[i][3] ? 32'h8000 : 32'h3333, {16'h0, resp_data});
		end
	endtask
	task automatic t_supply;
		@(posedge clk);
		flg <= 14'h2000;
		cmd(6'h01, 4'h1, 1'h0);
		@(posedge clk);
		tmr <= 1'h1;
		cmd(6'h01, 4'h1, 1'h1);
		chk("status", 32'hC, {28'h0, resp_status});
		chk("data", 32'h8000, {16'h0, resp_data});
	endtask
	task automatic complete_run;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		#10_000_000;
		mismatches++;
		complete_run();
	end
	initial begin
		reset_n = 1'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		slot_src = 2'h0;
		flg = 14'h0;
		tmr = 1'h0;
		repeat (4) @(posedge clk);
		reset_n <= 1'h1;
		t_pre();
		t_lock();
		t_bcast();
		t_len();
		t_nosts();
		t_status();
		t_supply();
		t_diag();
		complete_run();
	end
endmodule // testbench
